// ==== core/dps_pkg.sv ====
// shared constants, states and carriers of the power-up and restore sequencer
package dps_pkg;

  // clock period of clk_i in ns (125 MHz)
  localparam int NS_PER_CYC                    = 8;

  // figures as printed, in their own units
  localparam int POWERUP_INIT_TIME_US          = 150;
  localparam int RESTORE_PULSE_WIDTH_NS        = 200;
  localparam int RESTORE_HIGH_TO_SELECT_GAP_NS = 200;
  localparam int RESTORE_LOW_TO_SELECT_GAP_NS  = 400;

  // longest time rounds down, least times round up
  localparam int POWERUP_INIT_CYC =
    (POWERUP_INIT_TIME_US * 1000) / NS_PER_CYC;
  localparam int RESTORE_PULSE_CYC =
    (RESTORE_PULSE_WIDTH_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int HIGH_GAP_CYC =
    (RESTORE_HIGH_TO_SELECT_GAP_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int LOW_GAP_CYC =
    (RESTORE_LOW_TO_SELECT_GAP_NS + NS_PER_CYC - 1) / NS_PER_CYC;

  // counter widths
  localparam int INIT_W = 16;
  localparam int GAP_W  = 8;
  localparam int ROW_W  = 13;
  localparam int REF_W  = 4;

  // self-refresh row counter default and row step period
  localparam logic [ROW_W-1:0] ROW_DEFAULT   = 13'h0000;
  localparam logic [ROW_W-1:0] ROW_STEP      = 13'h0001;
  localparam logic [REF_W-1:0] REF_TICK_LAST = 4'h7;
  localparam logic [REF_W-1:0] REF_ZERO      = 4'h0;
  localparam logic [REF_W-1:0] REF_STEP      = 4'h1;
  localparam logic [GAP_W-1:0] GAP_ZERO      = 8'h00;
  localparam logic [GAP_W-1:0] GAP_STEP      = 8'h01;
  localparam logic [GAP_W-1:0] HIGH_GAP_LAST = GAP_W'(HIGH_GAP_CYC - 1);
  localparam logic [GAP_W-1:0] LOW_GAP_LAST  = GAP_W'(LOW_GAP_CYC - 1);
  localparam logic [INIT_W-1:0] INIT_ZERO    = 16'h0000;
  localparam logic [INIT_W-1:0] INIT_STEP    = 16'h0001;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_WAIT_HIGH = 5'h01,
    ST_INIT      = 5'h02,
    ST_RESTORE   = 5'h04,
    ST_RECOVER   = 5'h08,
    ST_READY     = 5'h10
  } dps_seq_t;

  // power states, one-hot
  typedef enum logic [2:0] {
    PWR_STANDBY = 3'h1,
    PWR_SLEEP   = 3'h2,
    PWR_DEEPEST = 3'h4
  } dps_pwr_t;

  // pins from the host, both active low
  typedef struct packed {
    logic restore_n;
    logic cs_n;
  } dps_pins_t;

  // status carried out of the sequencer
  typedef struct packed {
    logic ready;
    logic init_busy;
    logic cfg_default;
    logic refresh_en;
    logic array_valid;
  } dps_stat_t;

endpackage

// ==== core/dps_sync3.sv ====
// three flip-flop pin synchroniser with agreement filter
`timescale 1ns/1ns
module dps_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic s1_reg;  // first stage, read only by s2
  logic s2_reg;  // second stage
  logic s3_reg;  // third stage
  logic q_reg;   // filtered level
  logic q_next;

  // a change counts only once stages two and three agree
  always_comb begin
    q_next = q_reg;
    if (s2_reg == s3_reg) begin
      q_next = s3_reg;
    end
  end

  // shift chain and filtered level
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      q_reg  <= RST_VAL;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q_o = q_reg;

endmodule

// ==== core/dps_seq.sv ====
// power-up initialisation and hardware restore sequencer
`timescale 1ns/1ns
//
// Contract
// [RULE1] finish self-initialisation within 150 us
// [RULE2] host keeps select high during power-up
// [RULE3] restore low at power-up delays initialisation
// [RULE4] host issues no transaction during initialisation
// [RULE5] ready for transactions after initialisation
// [RULE6] restore low returns device to standby
// [RULE7] host holds restore low at least 200 ns
// [RULE8] host waits 200 ns after restore rises
// [RULE9] 400 ns from restore fall to select
// [RULE10] restore returns configuration to defaults
// [RULE11] restore low stops refresh, array invalid
// [RULE12] row counter defaulted, refresh resumes after
// [RULE13] restore forces exit from sleep
// [RULE14] restore forces exit from deepest power-down
// [RULE15] host treats array as lost after restore
// [RULE16] select ignored while restoring, recovering, initialising
module dps_seq
  import dps_pkg::*;
#(
  parameter int unsigned INIT_CYC = POWERUP_INIT_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire dps_pins_t  pins_i,
  input  wire logic       sleep_req_i,
  input  wire logic       deepest_powerdown_req_i,
  input  wire logic       wake_req_i,
  output dps_stat_t       status_o,
  output dps_pwr_t        pwr_state_o,
  output logic [ROW_W-1:0] refresh_row_o,
  output logic            access_start_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic restore_f;  // filtered restore level, high = released
  logic cs_f;       // filtered select level, high = deselected

  // restore starts low so power-up waits for a seen release
  dps_sync3 #(.RST_VAL(1'b0)) u_sync_restore (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      (pins_i.restore_n),
    .q_o      (restore_f)
  );

  dps_sync3 #(.RST_VAL(1'b1)) u_sync_cs (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      (pins_i.cs_n),
    .q_o      (cs_f)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state and counters

  localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYC - 1);

  dps_seq_t         state_reg, state_next;     // sequencer state
  dps_pwr_t         pwr_reg, pwr_next;         // power state
  logic [INIT_W-1:0] init_cnt_reg, init_cnt_next; // initialisation count
  logic [GAP_W-1:0] fall_cnt_reg, fall_cnt_next; // cycles since restore fell
  logic [GAP_W-1:0] gap_cnt_reg, gap_cnt_next;   // cycles since restore rose
  logic             init_done_reg, init_done_next; // first init completed
  logic             restore_d_reg;             // previous filtered restore
  logic             cs_d_reg;                  // previous filtered select
  logic             gaps_met;                  // both select gaps elapsed

  // recovery needs the high gap and the low-to-select gap both elapsed
  assign gaps_met = (gap_cnt_reg >= HIGH_GAP_LAST) &&
                    (fall_cnt_reg >= LOW_GAP_LAST);

  // next state of the sequencer and the power state
  always_comb begin
    state_next     = state_reg;
    pwr_next       = pwr_reg;
    init_cnt_next  = init_cnt_reg;
    fall_cnt_next  = fall_cnt_reg;
    gap_cnt_next   = gap_cnt_reg;
    init_done_next = init_done_reg;
    // count since the fall saturates so long pulses do not wrap
    if (restore_d_reg && !restore_f) begin
      fall_cnt_next = GAP_ZERO;
    end else if (fall_cnt_reg != LOW_GAP_LAST) begin
      fall_cnt_next = fall_cnt_reg + GAP_STEP;
    end
    unique case (state_reg)
      // [RULE3] hold off initialisation
      ST_WAIT_HIGH: begin
        if (restore_f) begin
          state_next    = ST_INIT;
          init_cnt_next = INIT_ZERO;
        end
      end
      // [RULE1] bounded initialisation interval
      ST_INIT: begin
        if (!restore_f) begin
          state_next = ST_RESTORE;
        end else if (init_cnt_reg == INIT_LAST) begin
          state_next     = ST_READY;
          init_done_next = 1'b1;
        end else begin
          init_cnt_next = init_cnt_reg + INIT_STEP;
        end
      end
      // restore held low, wait for release
      ST_RESTORE: begin
        if (restore_f) begin
          state_next   = ST_RECOVER;
          gap_cnt_next = GAP_ZERO;
        end
      end
      // [RULE16] post-restore recovery window
      ST_RECOVER: begin
        if (!restore_f) begin
          state_next = ST_RESTORE;
        end else if (gaps_met) begin
          // an interrupted first init is run again in full
          state_next    = init_done_reg ? ST_READY : ST_INIT;
          init_cnt_next = INIT_ZERO;
        end else if (gap_cnt_reg != HIGH_GAP_LAST) begin
          gap_cnt_next = gap_cnt_reg + GAP_STEP;
        end
      end
      // [RULE5] normal operation
      ST_READY: begin
        if (!restore_f) begin
          state_next = ST_RESTORE;
        end else if (pwr_reg == PWR_STANDBY) begin
          if (deepest_powerdown_req_i) begin
            pwr_next = PWR_DEEPEST;
          end else if (sleep_req_i) begin
            pwr_next = PWR_SLEEP;
          end
        end else if (wake_req_i) begin
          pwr_next = PWR_STANDBY;
        end
      end
    endcase
    // [RULE6] restore returns to standby
    // [RULE13] leaves sleep, [RULE14] leaves deepest power-down
    if (!restore_f) begin
      pwr_next = PWR_STANDBY;
    end
  end

  // sequencer registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg     <= ST_WAIT_HIGH;
      pwr_reg       <= PWR_STANDBY;
      init_cnt_reg  <= INIT_ZERO;
      fall_cnt_reg  <= GAP_ZERO;
      gap_cnt_reg   <= GAP_ZERO;
      init_done_reg <= 1'b0;
      restore_d_reg <= 1'b0;
      cs_d_reg      <= 1'b1;
    end else begin
      state_reg     <= state_next;
      pwr_reg       <= pwr_next;
      init_cnt_reg  <= init_cnt_next;
      fall_cnt_reg  <= fall_cnt_next;
      gap_cnt_reg   <= gap_cnt_next;
      init_done_reg <= init_done_next;
      restore_d_reg <= restore_f;
      cs_d_reg      <= cs_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // self-refresh and outputs

  logic [REF_W-1:0] ref_cnt_reg, ref_cnt_next;  // row step prescaler
  logic [ROW_W-1:0] row_reg, row_next;          // self-refresh row
  dps_stat_t        stat_reg, stat_next;        // registered status
  logic             access_reg, access_next;    // accepted select pulse
  logic             refresh_on;                 // refresh runs this cycle

  // refresh stops while restore is low and in deepest power-down
  assign refresh_on = (state_next != ST_RESTORE) &&
                      (state_next != ST_WAIT_HIGH) &&
                      (pwr_next != PWR_DEEPEST);

  // next refresh row, status and select acceptance
  always_comb begin
    ref_cnt_next = ref_cnt_reg;
    row_next     = row_reg;
    if (state_next == ST_RESTORE) begin
      // [RULE12] row counter back to default
      ref_cnt_next = REF_ZERO;
      row_next     = ROW_DEFAULT;
    end else if (refresh_on) begin
      if (ref_cnt_reg == REF_TICK_LAST) begin
        ref_cnt_next = REF_ZERO;
        row_next     = row_reg + ROW_STEP;
      end else begin
        ref_cnt_next = ref_cnt_reg + REF_STEP;
      end
    end
    stat_next.ready       = (state_next == ST_READY);
    stat_next.init_busy   = (state_next == ST_INIT);
    // [RULE10] configuration held at defaults
    stat_next.cfg_default = (state_next == ST_RESTORE) ||
                            (state_next == ST_WAIT_HIGH);
    // [RULE11] refresh stopped, array invalid
    stat_next.refresh_en  = refresh_on;
    stat_next.array_valid = stat_reg.array_valid;
    if (state_next == ST_RESTORE) begin
      stat_next.array_valid = 1'b0;
    end else if (state_reg == ST_INIT && state_next == ST_READY) begin
      stat_next.array_valid = 1'b1;
    end
    // [RULE16] only a select in ready standby starts an access
    access_next = cs_d_reg && !cs_f && restore_f &&
                  (state_reg == ST_READY) && (pwr_reg == PWR_STANDBY);
  end

  // refresh and output registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_cnt_reg <= REF_ZERO;
      row_reg     <= ROW_DEFAULT;
      stat_reg    <= '{ready: 1'b0, init_busy: 1'b0, cfg_default: 1'b1,
                       refresh_en: 1'b0, array_valid: 1'b0};
      access_reg  <= 1'b0;
    end else begin
      ref_cnt_reg <= ref_cnt_next;
      row_reg     <= row_next;
      stat_reg    <= stat_next;
      access_reg  <= access_next;
    end
  end

  assign status_o       = stat_reg;
  assign pwr_state_o    = pwr_reg;
  assign refresh_row_o  = row_reg;
  assign access_start_o = access_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_init_done;
    @(posedge clk_i) disable iff (!resetn_i)
    (state_reg == ST_INIT && restore_f && init_cnt_reg == INIT_LAST)
      |=> (status_o.ready && status_o.array_valid);
  endproperty
  a_init_done: assert property (p_init_done) // [RULE1]
    else $error("init did not end at its last count");

  property p_init_max;
    @(posedge clk_i) disable iff (!resetn_i)
    state_reg == ST_INIT |-> init_cnt_reg <= INIT_LAST;
  endproperty
  a_init_max: assert property (p_init_max) // [RULE1]
    else $error("init count ran past its bound");

  property p_wait_low;
    @(posedge clk_i) disable iff (!resetn_i)
    (state_reg == ST_WAIT_HIGH && !restore_f) |=>
      (state_reg == ST_WAIT_HIGH && !status_o.init_busy);
  endproperty
  a_wait_low: assert property (p_wait_low) // [RULE3]
    else $error("init started with restore low");

  property p_ready_state;
    @(posedge clk_i) disable iff (!resetn_i)
    status_o.ready |-> (!status_o.init_busy && !status_o.cfg_default);
  endproperty
  a_ready_state: assert property (p_ready_state) // [RULE5]
    else $error("ready while busy or defaulted");

  property p_to_standby;
    @(posedge clk_i) disable iff (!resetn_i)
    (!restore_f && pwr_reg == PWR_SLEEP) |=> pwr_reg == PWR_STANDBY;
  endproperty
  a_to_standby: assert property (p_to_standby) // [RULE13]
    else $error("sleep not left on restore");

  property p_leave_deepest;
    @(posedge clk_i) disable iff (!resetn_i)
    (!restore_f && pwr_reg == PWR_DEEPEST) |=> pwr_reg == PWR_STANDBY;
  endproperty
  a_leave_deepest: assert property (p_leave_deepest) // [RULE14]
    else $error("deepest power-down not left on restore");

  property p_cfg_default;
    @(posedge clk_i) disable iff (!resetn_i)
    (!restore_f && state_reg != ST_WAIT_HIGH) |=>
      (status_o.cfg_default && pwr_reg == PWR_STANDBY);
  endproperty
  a_cfg_default: assert property (p_cfg_default) // [RULE10]
    else $error("config not defaulted under restore");

  property p_refresh_stop;
    @(posedge clk_i) disable iff (!resetn_i)
    !restore_f |=> (!status_o.refresh_en && !status_o.array_valid);
  endproperty
  a_refresh_stop: assert property (p_refresh_stop) // [RULE11]
    else $error("refresh ran with restore low");

  property p_row_default;
    @(posedge clk_i) disable iff (!resetn_i)
    state_reg == ST_RESTORE |-> refresh_row_o == ROW_DEFAULT;
  endproperty
  a_row_default: assert property (p_row_default) // [RULE12]
    else $error("row counter not at default");

  property p_refresh_resume;
    @(posedge clk_i) disable iff (!resetn_i)
    (state_reg == ST_RESTORE && restore_f && pwr_reg == PWR_STANDBY)
      |=> status_o.refresh_en;
  endproperty
  a_refresh_resume: assert property (p_refresh_resume) // [RULE12]
    else $error("refresh did not resume after restore");

  property p_recover_quiet;
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(restore_f) |=> (!status_o.ready && !access_start_o) [*8];
  endproperty
  a_recover_quiet: assert property (p_recover_quiet) // [RULE16]
    else $error("ready too soon after restore");

  property p_no_access;
    @(posedge clk_i) disable iff (!resetn_i)
    (state_reg != ST_READY) |=> !access_start_o;
  endproperty
  a_no_access: assert property (p_no_access) // [RULE16]
    else $error("select accepted outside ready");

  c_init_done: cover property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(status_o.ready));
  c_restore_back: cover property (@(posedge clk_i) disable iff (!resetn_i)
    (state_reg == ST_RECOVER) ##1 (state_reg == ST_READY));
  c_sleep: cover property (@(posedge clk_i) disable iff (!resetn_i)
    (pwr_reg == PWR_SLEEP) ##1 (pwr_reg == PWR_STANDBY));
  c_deepest: cover property (@(posedge clk_i) disable iff (!resetn_i)
    (pwr_reg == PWR_DEEPEST) && !restore_f);

endmodule

// ==== tb/dps_host_model.sv ====
// host controller model driving the restore and select pins
`timescale 1ns/1ns
module dps_host_model
  import dps_pkg::*;
#(
  parameter int PULSE_LCYC = 2,  // restore low width, link cycles
  parameter int HIGH_LCYC  = 2,  // restore rise to select gap
  parameter int LOW_LCYC   = 4,  // restore fall to select gap
  parameter int INIT_LCYC  = 4   // power-up wait before any select
) (
  input  wire logic link_clk_i,
  input  wire logic resetn_i,
  input  wire logic restore_req_i,
  input  wire logic sel_req_i,
  input  wire logic rude_i,
  output dps_pins_t pins_o
);
  logic       rst_n_reg,  rst_n_next;   // restore pin level
  logic       cs_n_reg,   cs_n_next;    // select pin level
  logic [7:0] low_reg,    low_next;     // cycles since restore fell
  logic [7:0] high_reg,   high_next;    // cycles since restore rose
  logic [7:0] init_reg,   init_next;    // cycles of restore high ever
  logic       gaps_ok;                  // all select gaps elapsed

  //////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    rst_n_next = rst_n_reg;
    if (rst_n_reg) begin
      rst_n_next = ~restore_req_i;
    end else if (!restore_req_i && low_reg >= 8'(PULSE_LCYC)) begin
      rst_n_next = 1'b1;
    end
    low_next  = (rst_n_reg && !rst_n_next) ? 8'h00 :
                (low_reg == 8'hFF) ? low_reg : low_reg + 8'h01;
    high_next = !rst_n_reg ? 8'h00 :
                (high_reg == 8'hFF) ? high_reg : high_reg + 8'h01;
    init_next = (rst_n_reg && init_reg != 8'hFF) ? init_reg + 8'h01
                                                  : init_reg;
    gaps_ok   = rst_n_reg && high_reg >= 8'(HIGH_LCYC) &&
                low_reg >= 8'(LOW_LCYC) && init_reg >= 8'(INIT_LCYC);
    // rude mode is only used where a refusal is the point
    cs_n_next = ~(sel_req_i && (rude_i || gaps_ok));
  end

  // register stage; supply-up holds restore low and select high
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_n_reg <= 1'b0;
      cs_n_reg  <= 1'b1;
      low_reg   <= 8'hFF;
      high_reg  <= 8'h00;
      init_reg  <= 8'h00;
    end else begin
      rst_n_reg <= rst_n_next;
      cs_n_reg  <= cs_n_next;
      low_reg   <= low_next;
      high_reg  <= high_next;
      init_reg  <= init_next;
    end
  end

  assign pins_o = '{restore_n: rst_n_reg, cs_n: cs_n_reg};
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench of the power-up and restore sequencer
`timescale 1ns/1ns
module tb_top;
  import dps_pkg::*;
  localparam int INIT_N = 20;  // shortened init interval

  // one row of power-state traffic and its outcome
  typedef struct packed {
    logic     sleep;
    logic     deep;
    logic     wake;
    dps_pwr_t pwr;
    logic     ref_en;
  } dps_row_t;

  localparam dps_row_t ROWS [8] = '{
    '{1'b1, 1'b0, 1'b0, PWR_SLEEP,   1'b1},
    '{1'b0, 1'b0, 1'b1, PWR_STANDBY, 1'b1},
    '{1'b0, 1'b1, 1'b0, PWR_DEEPEST, 1'b0},
    '{1'b0, 1'b0, 1'b1, PWR_STANDBY, 1'b1},
    '{1'b1, 1'b1, 1'b0, PWR_DEEPEST, 1'b0},
    '{1'b1, 1'b0, 1'b0, PWR_DEEPEST, 1'b0},
    '{1'b0, 1'b0, 1'b1, PWR_STANDBY, 1'b1},
    '{1'b0, 1'b0, 1'b1, PWR_STANDBY, 1'b1}
  };

  logic             clk_i    = 1'b0;  // system clock
  logic             lclk     = 1'b0;  // host link clock
  logic             resetn_i = 1'b0;  // supply-up reset
  logic             restore_req = 1'b1;
  logic             sel_req  = 1'b0;
  logic             rude     = 1'b0;
  logic             sleep    = 1'b0;
  logic             deep     = 1'b0;
  logic             wake     = 1'b0;
  dps_pins_t        pins;
  dps_stat_t        stat;
  dps_pwr_t         pwr;
  logic [ROW_W-1:0] row;
  logic             acc;
  int               miscompares = 0;
  int               num_checks  = 0;
  int               pulses      = 0;
  int               base        = 0;  // pulse count at start of a case
  int               n;

  always #4 clk_i = ~clk_i;
  // 125 ns link period, phase unrelated to the system clock
  always begin
    #62 lclk = ~lclk;
    #63 lclk = ~lclk;
  end

  dps_seq #(.INIT_CYC(INIT_N)) u_dps_seq (
    .clk_i                   (clk_i),
    .resetn_i                (resetn_i),
    .pins_i                  (pins),
    .sleep_req_i             (sleep),
    .deepest_powerdown_req_i (deep),
    .wake_req_i              (wake),
    .status_o                (stat),
    .pwr_state_o             (pwr),
    .refresh_row_o           (row),
    .access_start_o          (acc)
  );

  dps_host_model u_dps_host_model (
    .link_clk_i    (lclk),
    .resetn_i      (resetn_i),
    .restore_req_i (restore_req),
    .sel_req_i     (sel_req),
    .rude_i        (rude),
    .pins_o        (pins)
  );

  // count cycles with the access pulse high
  always @(posedge clk_i) begin
    if (acc === 1'b1) pulses <= pulses + 1;
  end

  //////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic stop_test;
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // inputs change 1 ns after the rising edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  // bounded wait for ready, returns cycles waited
  task automatic wait_ready(output int k);
    k = 0;
    while (stat.ready !== 1'b1 && k < 3000) begin
      cyc(1);
      k++;
    end
    check("ready_seen", 16'(stat.ready), 16'h0001);
  endtask

  // one-cycle pulse on the power-state requests
  task automatic pwr_req(input logic s, input logic d, input logic w);
    sleep = s;
    deep  = d;
    wake  = w;
    cyc(1);
    {sleep, deep, wake} = 3'h0;
    cyc(4);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    cyc(6);
    // reset values while supply is coming up
    check("rst_ready", 16'(stat.ready), 16'h0000);
    check("rst_cfg", 16'(stat.cfg_default), 16'h0001);
    check("rst_valid", 16'(stat.array_valid), 16'h0000);
    check("rst_pwr", 16'(pwr), 16'(PWR_STANDBY));
    check("rst_row", 16'(row), 16'(ROW_DEFAULT));
    cyc(6);
    resetn_i = 1'b1;
    cyc(100);
    // init waits while restore is held low
    check("hold_busy", 16'(stat.init_busy), 16'h0000);
    check("hold_ready", 16'(stat.ready), 16'h0000);
    // rude select during init must start nothing
    restore_req = 1'b0;
    sel_req     = 1'b1;
    rude        = 1'b1;
    n = 0;
    while (stat.init_busy !== 1'b1 && n < 500) begin
      cyc(1);
      n++;
    end
    wait_ready(n);
    // never later than the init interval allows
    check("init_len", 16'(n >= INIT_N - 2 && n <= INIT_N),
          16'h0001);
    check("init_valid", 16'(stat.array_valid), 16'h0001);
    check("init_ref", 16'(stat.refresh_en), 16'h0001);
    check("init_acc", 16'(pulses), 16'h0000);
    sel_req = 1'b0;
    rude    = 1'b0;
    cyc(60);
    // a polite select once ready gives one pulse
    base    = pulses;
    sel_req = 1'b1;
    cyc(60);
    sel_req = 1'b0;
    cyc(40);
    check("sel_acc", 16'(pulses - base), 16'h0001);
    // power-state table
    foreach (ROWS[i]) begin
      pwr_req(ROWS[i].sleep, ROWS[i].deep, ROWS[i].wake);
      check("row_pwr", 16'(pwr), 16'(ROWS[i].pwr));
      check("row_ref", 16'(stat.refresh_en), 16'(ROWS[i].ref_en));
    end
    // a select in sleep starts no access
    pwr_req(1'b1, 1'b0, 1'b0);
    base    = pulses;
    sel_req = 1'b1;
    cyc(60);
    sel_req = 1'b0;
    cyc(40);
    check("slp_acc", 16'(pulses - base), 16'h0000);
    pwr_req(1'b0, 1'b0, 1'b1);
    // restore from standby, sleep and deepest power-down
    for (int m = 0; m < 3; m++) begin
      pwr_req(m == 1, m == 2, 1'b0);
      base        = pulses;
      restore_req = 1'b1;
      sel_req     = 1'b1;
      rude        = 1'b1;
      cyc(40);
      check("rs_pwr", 16'(pwr), 16'(PWR_STANDBY));
      check("rs_cfg", 16'(stat.cfg_default), 16'h0001);
      check("rs_ref", 16'(stat.refresh_en), 16'h0000);
      check("rs_valid", 16'(stat.array_valid), 16'h0000);
      check("rs_ready", 16'(stat.ready), 16'h0000);
      check("rs_row", 16'(row), 16'(ROW_DEFAULT));
      sel_req     = 1'b0;
      rude        = 1'b0;
      restore_req = 1'b0;
      wait_ready(n);
      check("rc_gap", 16'(n >= HIGH_GAP_CYC), 16'h0001);
      check("rc_acc", 16'(pulses - base), 16'h0000);
      check("rc_ref", 16'(stat.refresh_en), 16'h0001);
      check("rc_cfg", 16'(stat.cfg_default), 16'h0000);
      cyc(40);
      check("rc_row", 16'(row !== ROW_DEFAULT), 16'h0001);
    end
    stop_test;
  end

  // watchdog: the run takes about 1000 cycles, allow five times that
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    stop_test;
  end
endmodule
